// ---- sim/phy_alt_interrupt_logic_tb.sv ----
`timescale 1ns/100ps
module phy_alt_interrupt_logic_tb;
	import phy_irq_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic mdc, mdio_drv, mdio_drv_oe, mdio_o, mdio_oe, irq_out_n;
	// Source levels by flag position; bit 4 means link down
	logic [8:0] ev = 9'h080;
	wire logic mdio;
	int errors = 0;
	int compares = 0;

	// Pull-up on the management data line
	assign mdio = mdio_oe ? mdio_o : (mdio_drv_oe ? mdio_drv : 1'b1);
	always #20 clock = ~clock;

	phy_alt_interrupt_logic dut (
		.clock(clock),
		.rst(rst),
		.mdc(mdc),
		.mdio_i(mdio),
		.mdio_o(mdio_o),
		.mdio_oe(mdio_oe),
		.energy_detect(ev[7]),
		.an_complete(ev[6]),
		.remote_fault(ev[5]),
		.link_status(!ev[4]),
		.lp_ack(ev[3]),
		.par_fault(ev[2]),
		.page_rx(ev[1]),
		.wake_status(ev[8] ? 4'h2 : 4'h0),
		.irq_out_n(irq_out_n)
	);

	smi_master_model bfm (
		.clock(clock),
		.mdc(mdc),
		.mdio_drv(mdio_drv),
		.mdio_drv_oe(mdio_drv_oe),
		.mdio(mdio)
	);

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bfm.frame(OP_WRITE, a, d);
	endtask : wr

	task automatic rd_chk(input string name, input logic [4:0] a, input logic [15:0] exp);
		bfm.frame(OP_READ, a, 16'h0000);
		check(name, exp, bfm.rd_q);
	endtask : rd_chk

	task automatic irq_chk(input logic exp);
		check("irq_out_n", {15'h0000, exp}, {15'h0000, irq_out_n});
	endtask : irq_chk

	// Margin covers edge detect plus flag register
	task automatic set_ev(input logic [8:0] v);
		@(posedge clock);
		ev <= v;
		repeat (6) @(posedge clock);
	endtask : set_ev

	task automatic print_verdict;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		$display("[ERR] watchdog expected finish seen timeout");
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		irq_chk(1'b1);
		rd_chk("mode", REG_MODE_CTRL, 16'h0002);
		rd_chk("flags", REG_IRQ_FLAGS, 16'h0080);
		// Primary scheme: the read above empties the flags while energy stays high
		rd_chk("flags read clear", REG_IRQ_FLAGS, 16'h0000);
		rd_chk("mask", REG_IRQ_MASK, 16'h0000);
		rd_chk("unmapped", 5'h05, 16'h0000);
		set_ev(9'h000);
		$display("test reset done");
		wr(REG_MODE_CTRL, 16'h0040);
		rd_chk("mode", REG_MODE_CTRL, 16'h0040);
		wr(REG_IRQ_MASK, 16'hFFFF);
		rd_chk("mask", REG_IRQ_MASK, 16'h01FE);
		rd_chk("flags", REG_IRQ_FLAGS, 16'h0000);
		irq_chk(1'b1);
		$display("test setup done");
		// Each source: set, refused clear while active, kept after drop, then cleared
		for (int i = 1; i <= 8; i++) begin
			set_ev(9'h001 << i);
			irq_chk(1'b0);
			rd_chk("flag set", REG_IRQ_FLAGS, 16'h0001 << i);
			wr(REG_IRQ_FLAGS, 16'h0001 << i);
			rd_chk("flag kept", REG_IRQ_FLAGS, 16'h0001 << i);
			irq_chk(1'b0);
			set_ev(9'h000);
			rd_chk("flag held", REG_IRQ_FLAGS, 16'h0001 << i);
			wr(REG_IRQ_FLAGS, 16'h0001 << i);
			rd_chk("flag clear", REG_IRQ_FLAGS, 16'h0000);
			irq_chk(1'b1);
		end
		$display("test sources done");
		set_ev(9'h080);
		irq_chk(1'b0);
		wr(REG_IRQ_MASK, 16'h0000);
		irq_chk(1'b1);
		rd_chk("flag masked", REG_IRQ_FLAGS, 16'h0080);
		wr(REG_IRQ_MASK, 16'h0080);
		irq_chk(1'b0);
		$display("test mask done");
		// Back in primary scheme the flag clears on the low level alone
		wr(REG_MODE_CTRL, 16'h0000);
		set_ev(9'h000);
		irq_chk(1'b1);
		$display("test scheme done");
		print_verdict();
	end
endmodule : phy_alt_interrupt_logic_tb

// ---- sim/smi_master_model.sv ----
`timescale 1ns/100ps
module smi_master_model (
	input wire logic clock,
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_drv_oe,
	input wire logic mdio
);
	import phy_irq_pkg::*;
	logic [15:0] rd_q;

	// Clock parked low outside frames
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_drv_oe = 1'b0;
		rd_q = 16'h0000;
	end

	// Bit set up while clock is low; 5 clocks each half keeps 200 ns halves, 400 ns cycle
	task automatic bit_cycle(input logic b, input logic drv);
		@(posedge clock);
		mdc <= 1'b0;
		mdio_drv <= b;
		mdio_drv_oe <= drv;
		repeat (5) @(posedge clock);
		rd_q <= {rd_q[14:0], mdio};
		mdc <= 1'b1;
		repeat (4) @(posedge clock);
	endtask : bit_cycle

	// Whole frame with its own preamble; read releases the line from turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] reg_a, input logic [15:0] wd);
		logic [31:0] w;
		w = {2'b01, op, PHY_ADDR_DEFAULT, reg_a, 2'b10, wd};
		repeat (32) bit_cycle(1'b1, 1'b1);
		for (int i = 31; i >= 0; i--) begin
			bit_cycle(w[i], (op == OP_WRITE) || (i > 17));
		end
		@(posedge clock);
		mdc <= 1'b0;
		mdio_drv_oe <= 1'b0;
		repeat (10) @(posedge clock);
	endtask : frame
endmodule : smi_master_model

// ---- src/phy_alt_interrupt_logic.sv ----
`timescale 1ns/100ps
module phy_alt_interrupt_logic #(
	parameter logic [4:0] PHY_ADDR = phy_irq_pkg::PHY_ADDR_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	input wire logic energy_detect,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_status,
	input wire logic lp_ack,
	input wire logic par_fault,
	input wire logic page_rx,
	input wire logic [phy_irq_pkg::WAKE_WIDTH-1:0] wake_status,
	output logic irq_out_n
);
	import phy_irq_pkg::*;

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_num);
		hit = (addr == reg_num);
	endfunction : hit

	smi_reg_if bus ();

	smi_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_smi (
		.clock(clock),
		.rst(rst),
		.mdc(mdc),
		.mdio_i(mdio_i),
		.mdio_o(mdio_o),
		.mdio_oe(mdio_oe),
		.bus(bus)
	);

	logic alt_irq_scheme_sel_q, alt_irq_scheme_sel_d;
	logic [15:0] flags_q, flags_d;
	logic [15:0] mask_q, mask_d;
	logic [15:0] src_prev_q, src_prev_d;
	logic irq_n_q, irq_n_d;
	logic [15:0] src_vec, rise, deassert_ok, w1c, clear;
	logic wr_flags, wr_mask, wr_mode, rd_flags;

	// Link-down is stored inverted so every source is active high
	always_comb begin
		src_vec = 16'h0000;
		src_vec[SRC_PAGE_BIT] = page_rx;
		src_vec[SRC_PAR_FAULT_BIT] = par_fault;
		src_vec[SRC_LP_ACK_BIT] = lp_ack;
		src_vec[SRC_LINK_DOWN_BIT] = ~link_status;
		src_vec[SRC_REM_FAULT_BIT] = remote_fault;
		src_vec[SRC_AN_DONE_BIT] = an_complete;
		src_vec[SRC_ENERGY_BIT] = energy_detect;
		src_vec[SRC_WAKE_BIT] = |wake_status;
	end

	assign wr_flags = bus.wr && hit(bus.addr, REG_IRQ_FLAGS);
	assign wr_mask = bus.wr && hit(bus.addr, REG_IRQ_MASK);
	assign wr_mode = bus.wr && hit(bus.addr, REG_MODE_CTRL);
	assign rd_flags = bus.rd && hit(bus.addr, REG_IRQ_FLAGS);

	assign rise = src_vec & ~src_prev_q & SRC_MASK;
	assign deassert_ok = ~src_vec & SRC_MASK;
	assign w1c = wr_flags ? (bus.wdata & SRC_MASK) : 16'h0000;

	always_comb begin
		src_prev_d = src_vec;
		alt_irq_scheme_sel_d = alt_irq_scheme_sel_q;
		mask_d = mask_q;
		if (wr_mode) begin
			alt_irq_scheme_sel_d = bus.wdata[MODE_ALT_SEL_BIT];
		end
		if (wr_mask) begin
			mask_d = bus.wdata & SRC_MASK;
		end
		if (alt_irq_scheme_sel_q) begin
			// A one written only clears where the source has gone away
			clear = w1c & deassert_ok;
		end else begin
			// Primary scheme: read of the flags or the source's own low level, link-down excepted
			clear = (rd_flags ? SRC_MASK : 16'h0000) | (deassert_ok & PRI_LEVEL_CLR);
		end
		// New event in the clearing cycle is kept
		flags_d = (flags_q & ~clear) | rise;
		irq_n_d = ~|(flags_d & mask_d);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			alt_irq_scheme_sel_q <= ALT_SEL_RESET;
			flags_q <= FLAGS_RESET;
			mask_q <= MASK_RESET;
			src_prev_q <= 16'h0000;
			irq_n_q <= 1'b1;
		end else begin
			alt_irq_scheme_sel_q <= alt_irq_scheme_sel_d;
			flags_q <= flags_d;
			mask_q <= mask_d;
			src_prev_q <= src_prev_d;
			irq_n_q <= irq_n_d;
		end
	end

	assign irq_out_n = irq_n_q;

	// Only the three registers of this block answer; others read as zero
	always_comb begin
		bus.rdata = 16'h0000;
		if (hit(bus.addr, REG_MODE_CTRL)) begin
			bus.rdata[MODE_ALT_SEL_BIT] = alt_irq_scheme_sel_q;
			bus.rdata[MODE_ENERGY_BIT] = energy_detect;
		end else if (hit(bus.addr, REG_IRQ_FLAGS)) begin
			bus.rdata = flags_q;
		end else if (hit(bus.addr, REG_IRQ_MASK)) begin
			bus.rdata = mask_q;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic wr1_energy, wr1_link;
	assign wr1_energy = wr_flags && bus.wdata[SRC_ENERGY_BIT];
	assign wr1_link = wr_flags && bus.wdata[SRC_LINK_DOWN_BIT];

	property p_reset_primary;
		$past(rst) |-> !alt_irq_scheme_sel_q;
	endproperty
	a_reset_primary: assert property (p_reset_primary) else $error("scheme not primary after reset");

	property p_primary_level_clear;
		!alt_irq_scheme_sel_q && flags_q[SRC_ENERGY_BIT] && !energy_detect
			|=> !flags_q[SRC_ENERGY_BIT];
	endproperty
	a_primary_level_clear: assert property (p_primary_level_clear) else $error("primary energy flag held");

	property p_mask_clear;
		wr_mask && bus.wdata == 16'h0000 |=> irq_out_n;
	endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("mask clear left irq asserted");

	property p_alt_no_write_hold;
		alt_irq_scheme_sel_q && flags_q[SRC_ENERGY_BIT] && !wr1_energy
			|=> flags_q[SRC_ENERGY_BIT];
	endproperty
	a_alt_no_write_hold: assert property (p_alt_no_write_hold) else $error("alt flag cleared without write");

	property p_alt_clear;
		alt_irq_scheme_sel_q && wr1_link && link_status && !$past(~link_status)
			|=> !flags_q[SRC_LINK_DOWN_BIT];
	endproperty
	a_alt_clear: assert property (p_alt_clear) else $error("alt flag not cleared on condition");

	property p_alt_keep;
		alt_irq_scheme_sel_q && wr1_energy && energy_detect && flags_q[SRC_ENERGY_BIT]
			|=> flags_q[SRC_ENERGY_BIT] && (!mask_q[SRC_ENERGY_BIT] || !irq_out_n);
	endproperty
	a_alt_keep: assert property (p_alt_keep) else $error("alt flag lost while source high");

	property p_energy_event;
		$rose(energy_detect) && mask_q[SRC_ENERGY_BIT] && !wr_mask
			|=> flags_q[SRC_ENERGY_BIT] && !irq_out_n;
	endproperty
	a_energy_event: assert property (p_energy_event) else $error("energy event missed");

	property p_an_done;
		$rose(an_complete) |=> flags_q[SRC_AN_DONE_BIT];
	endproperty
	a_an_done: assert property (p_an_done) else $error("autoneg flag not set");

	property p_link_down;
		$fell(link_status) |=> flags_q[SRC_LINK_DOWN_BIT];
	endproperty
	a_link_down: assert property (p_link_down) else $error("link-down flag not set");

	property p_wake;
		$rose(|wake_status) |=> flags_q[SRC_WAKE_BIT];
	endproperty
	a_wake: assert property (p_wake) else $error("wake flag not set");

	property p_energy_at_reset;
		$past(rst) |-> flags_q[SRC_ENERGY_BIT] || !$past(rst, 2);
	endproperty
	a_energy_at_reset: assert property (p_energy_at_reset) else $error("energy flag not set at reset");

	property p_out_relation;
		irq_out_n == !(|(flags_q & mask_q));
	endproperty
	a_out_relation: assert property (p_out_relation) else $error("irq output mismatch");

	property p_page;
		$rose(page_rx) |=> flags_q[SRC_PAGE_BIT];
	endproperty
	a_page: assert property (p_page) else $error("page flag not set");

	property p_par_fault;
		$rose(par_fault) |=> flags_q[SRC_PAR_FAULT_BIT];
	endproperty
	a_par_fault: assert property (p_par_fault) else $error("parallel-detect flag not set");

	property p_rem_fault;
		$rose(remote_fault) |=> flags_q[SRC_REM_FAULT_BIT];
	endproperty
	a_rem_fault: assert property (p_rem_fault) else $error("remote-fault flag not set");

	property p_lp_ack;
		$rose(lp_ack) |=> flags_q[SRC_LP_ACK_BIT];
	endproperty
	a_lp_ack: assert property (p_lp_ack) else $error("partner acknowledge flag not set");

	// Register writes land one cycle after the strobe
	property p_mask_write;
		wr_mask |=> mask_q == ($past(bus.wdata) & SRC_MASK);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_mode_write;
		wr_mode |=> alt_irq_scheme_sel_q == $past(bus.wdata[MODE_ALT_SEL_BIT]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("scheme select write lost");

	property p_mode_hold;
		!wr_mode |=> $stable(alt_irq_scheme_sel_q);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("scheme select changed unasked");

	// Alternate scheme: no flag may fall unless the flags register was written
	property p_alt_level_hold;
		alt_irq_scheme_sel_q && !wr_flags
			|=> (flags_q & $past(flags_q)) == $past(flags_q);
	endproperty
	a_alt_level_hold: assert property (p_alt_level_hold) else $error("alt flag fell unasked");

	property p_alt_clear_energy;
		alt_irq_scheme_sel_q && wr1_energy && !energy_detect
			|=> !flags_q[SRC_ENERGY_BIT];
	endproperty
	a_alt_clear_energy: assert property (p_alt_clear_energy) else $error("alt energy flag kept");

	property p_alt_clear_wake;
		alt_irq_scheme_sel_q && wr_flags && bus.wdata[SRC_WAKE_BIT] && !(|wake_status)
			|=> !flags_q[SRC_WAKE_BIT];
	endproperty
	a_alt_clear_wake: assert property (p_alt_clear_wake) else $error("alt wake flag kept");

	property p_alt_keep_link;
		alt_irq_scheme_sel_q && wr1_link && !link_status && flags_q[SRC_LINK_DOWN_BIT]
			|=> flags_q[SRC_LINK_DOWN_BIT];
	endproperty
	a_alt_keep_link: assert property (p_alt_keep_link) else $error("alt link flag lost");

	property p_alt_keep_wake;
		alt_irq_scheme_sel_q && wr_flags && bus.wdata[SRC_WAKE_BIT] && (|wake_status)
			&& flags_q[SRC_WAKE_BIT] |=> flags_q[SRC_WAKE_BIT];
	endproperty
	a_alt_keep_wake: assert property (p_alt_keep_wake) else $error("alt wake flag lost");

	property p_alt_keep_an;
		alt_irq_scheme_sel_q && wr_flags && bus.wdata[SRC_AN_DONE_BIT] && an_complete
			&& flags_q[SRC_AN_DONE_BIT] |=> flags_q[SRC_AN_DONE_BIT];
	endproperty
	a_alt_keep_an: assert property (p_alt_keep_an) else $error("alt autoneg flag lost");

	// Primary scheme: a read empties the flags, link-down waits for one
	property p_primary_read_clear;
		!alt_irq_scheme_sel_q && rd_flags && !$rose(energy_detect)
			|=> !flags_q[SRC_ENERGY_BIT];
	endproperty
	a_primary_read_clear: assert property (p_primary_read_clear) else $error("primary read kept flag");

	property p_primary_link_kept;
		!alt_irq_scheme_sel_q && flags_q[SRC_LINK_DOWN_BIT] && !rd_flags
			|=> flags_q[SRC_LINK_DOWN_BIT];
	endproperty
	a_primary_link_kept: assert property (p_primary_link_kept) else $error("primary link flag lost");

	c_alt_clear: cover property (alt_irq_scheme_sel_q && wr1_link ##1 !flags_q[SRC_LINK_DOWN_BIT]);
	c_alt_keep: cover property (alt_irq_scheme_sel_q && wr1_energy && energy_detect);
	c_irq_low: cover property (!irq_out_n ##1 irq_out_n);
	c_primary_read: cover property (!alt_irq_scheme_sel_q && rd_flags && |flags_q);
	c_wake_keep: cover property (alt_irq_scheme_sel_q && wr_flags && (|wake_status));
endmodule : phy_alt_interrupt_logic

// ---- src/phy_irq_pkg.sv ----
package phy_irq_pkg;
	// Register numbers on the management bus
	localparam logic [4:0] REG_MODE_CTRL = 5'h11;
	localparam logic [4:0] REG_IRQ_FLAGS = 5'h1D;
	localparam logic [4:0] REG_IRQ_MASK = 5'h1E;

	// Field positions
	localparam int unsigned MODE_ALT_SEL_BIT = 6;
	localparam int unsigned MODE_ENERGY_BIT = 1;
	localparam int unsigned SRC_PAGE_BIT = 1;
	localparam int unsigned SRC_PAR_FAULT_BIT = 2;
	localparam int unsigned SRC_LP_ACK_BIT = 3;
	localparam int unsigned SRC_LINK_DOWN_BIT = 4;
	localparam int unsigned SRC_REM_FAULT_BIT = 5;
	localparam int unsigned SRC_AN_DONE_BIT = 6;
	localparam int unsigned SRC_ENERGY_BIT = 7;
	localparam int unsigned SRC_WAKE_BIT = 8;
	localparam int unsigned WAKE_WIDTH = 4;

	// Implemented source bits, and those the primary scheme clears on a low level
	localparam logic [15:0] SRC_MASK = 16'h01FE;
	localparam logic [15:0] PRI_LEVEL_CLR = 16'h01EE;

	// Reset values
	localparam logic [15:0] FLAGS_RESET = 16'h0080;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic ALT_SEL_RESET = 1'b0;

	// Management frame layout
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0C;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [4:0] TA_LAST = 5'h01;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;

	typedef enum logic [2:0] {
		SMI_IDLE = 3'b000,
		SMI_HDR = 3'b001,
		SMI_TA = 3'b010,
		SMI_RDATA = 3'b011,
		SMI_WDATA = 3'b100
	} smi_state_t;
endpackage : phy_irq_pkg

// ---- src/smi_reg_if.sv ----
`timescale 1ns/100ps
interface smi_reg_if;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic wr;
	logic rd;
	modport master(output addr, output wdata, output wr, output rd, input rdata);
	modport target(input addr, input wdata, input wr, input rd, output rdata);
endinterface : smi_reg_if

// ---- src/smi_slave.sv ----
`timescale 1ns/100ps
module smi_slave #(
	parameter logic [4:0] PHY_ADDR = phy_irq_pkg::PHY_ADDR_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	smi_reg_if.master bus
);
	import phy_irq_pkg::*;

	logic mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
	smi_state_t state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic [15:0] shift_q, shift_d;
	logic is_read_q, is_read_d, o_q, o_d, oe_q, oe_d, wr_q, wr_d, rd_q, rd_d;
	logic [4:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic mdc_rise;
	logic [12:0] hdr;

	assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
	assign hdr = {shift_q[11:0], mdio_s2_q};

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		is_read_d = is_read_q;
		o_d = o_q;
		oe_d = oe_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		// Register data arrives the cycle after the read strobe
		if (rd_q) begin
			shift_d = bus.rdata;
		end
		if (mdc_rise) begin
			case (state_q)
				SMI_IDLE: begin
					if (mdio_s2_q) begin
						cnt_d = (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
					end else if (cnt_q == PREAMBLE_LEN) begin
						state_d = SMI_HDR;
						cnt_d = 6'h00;
					end else begin
						cnt_d = 6'h00;
					end
				end
				SMI_HDR: begin
					shift_d = {shift_q[14:0], mdio_s2_q};
					cnt_d = cnt_q + 6'h01;
					// Start bit, op, address and register: thirteen bits in all
					if (cnt_q[4:0] == HDR_LAST) begin
						cnt_d = 6'h00;
						state_d = SMI_IDLE;
						// Frames for another address are ignored, MDIO left released
						if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
							addr_d = hdr[4:0];
							if (hdr[11:10] == OP_READ) begin
								state_d = SMI_TA;
								is_read_d = 1'b1;
								rd_d = 1'b1;
							end else if (hdr[11:10] == OP_WRITE) begin
								state_d = SMI_TA;
								is_read_d = 1'b0;
							end
						end
					end
				end
				SMI_TA: begin
					if (cnt_q[4:0] != TA_LAST) begin
						cnt_d = cnt_q + 6'h01;
						if (is_read_q) begin
							oe_d = 1'b1;
							o_d = 1'b0;
						end
					end else begin
						cnt_d = 6'h00;
						if (is_read_q) begin
							state_d = SMI_RDATA;
							o_d = shift_q[15];
							shift_d = {shift_q[14:0], 1'b0};
						end else begin
							state_d = SMI_WDATA;
						end
					end
				end
				SMI_RDATA: begin
					if (cnt_q[4:0] == DATA_LAST) begin
						oe_d = 1'b0;
						o_d = 1'b0;
						state_d = SMI_IDLE;
						cnt_d = 6'h00;
					end else begin
						o_d = shift_q[15];
						shift_d = {shift_q[14:0], 1'b0};
						cnt_d = cnt_q + 6'h01;
					end
				end
				SMI_WDATA: begin
					shift_d = {shift_q[14:0], mdio_s2_q};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q[4:0] == DATA_LAST) begin
						wdata_d = {shift_q[14:0], mdio_s2_q};
						wr_d = 1'b1;
						state_d = SMI_IDLE;
						cnt_d = 6'h00;
					end
				end
				default: begin
					state_d = SMI_IDLE;
					cnt_d = 6'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mdc_s1_q <= 1'b0;
			mdc_s2_q <= 1'b0;
			mdc_s3_q <= 1'b0;
			mdio_s1_q <= 1'b0;
			mdio_s2_q <= 1'b0;
			state_q <= SMI_IDLE;
			cnt_q <= 6'h00;
			shift_q <= 16'h0000;
			is_read_q <= 1'b0;
			o_q <= 1'b0;
			oe_q <= 1'b0;
			addr_q <= 5'h00;
			wdata_q <= 16'h0000;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			mdc_s1_q <= mdc;
			mdc_s2_q <= mdc_s1_q;
			mdc_s3_q <= mdc_s2_q;
			mdio_s1_q <= mdio_i;
			mdio_s2_q <= mdio_s1_q;
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			is_read_q <= is_read_d;
			o_q <= o_d;
			oe_q <= oe_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	assign mdio_o = o_q;
	assign mdio_oe = oe_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
endmodule : smi_slave
